// file: src/action_sync_map.vh
// register map, field positions, reset values and timing counts of the action trigger block
`ifndef ACTION_SYNC_MAP_VH
`define ACTION_SYNC_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_COMMAND     8'h08
`define REG_DEV_KEY     8'h0c
`define REG_GRP_KEY     8'h10
`define REG_GRP_MASK    8'h14
`define REG_SLOT_SEL    8'h18
`define REG_QUEUE_DEPTH 8'h1c
`define REG_TIME_LO     8'h20
`define REG_TIME_HI     8'h24
`define REG_CAPT_LO     8'h28
`define REG_CAPT_HI     8'h2c
`define REG_PATH_DELAY  8'h30
`define REG_OFFSET      8'h34

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_PTP_EN     0
`define STAT_SYNCED     0
`define STAT_MASTER     1
`define STAT_Q_FULL     2
`define STAT_Q_EMPTY    3
`define STAT_OVERFLOW   4
`define CMD_CLEAR       0
`define CMD_CAPTURE     1

// ****************************************************************
// reset values
// ****************************************************************
`define RST_CTRL        32'h0000_0000
`define RST_KEY         32'h0000_0000
`define RST_MASK        32'h0000_0000
`define SLOT_SEL_VALUE  32'h0000_0000
`define TIME_INIT       64'h0000_0000_0000_0000

// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ         25000
`define TICK_NS         (1000000 / `CLK_KHZ)
`define SYNC_PERIOD_MS  1000
`define SYNC_PERIOD_CYC (`SYNC_PERIOD_MS * `CLK_KHZ)
`define QUEUE_DEPTH     4

// ****************************************************************
// bus responses
// ****************************************************************
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// file: src/action_queue.v
// scheduling queue holding the trigger times of timestamped action commands
module action_queue #(
	parameter W     = 64,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire          clk_i,
	input  wire          rst_n_i,
	input  wire          push_i,
	input  wire [W-1:0]  push_data_i,
	input  wire          pop_i,
	output wire [W-1:0]  head_o,
	output wire          empty_o,
	output wire          full_o
);

	reg  [W-1:0]  mem [0:DEPTH-1];
	reg  [AW-1:0] wr_ptr_r;
	reg  [AW-1:0] rd_ptr_r;
	reg  [AW:0]   count_r;
	wire          do_push;
	wire          do_pop;

	assign empty_o = (count_r == {(AW+1){1'b0}});
	assign full_o  = (count_r == DEPTH[AW:0]);
	assign head_o  = mem[rd_ptr_r];
	assign do_push = push_i & ~full_o;
	assign do_pop  = pop_i & ~empty_o;

	always @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_ptr_r] <= push_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r  <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wr_ptr_r <= (wr_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_r <= (rd_ptr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
			case ({do_push, do_pop})
				2'b10:   count_r <= count_r + 1'b1;
				2'b01:   count_r <= count_r - 1'b1;
				default: count_r <= count_r;
			endcase
		end
	end

endmodule // action_queue

// file: src/action_sync_trigger.v
// action command filter, precision time slave and timed exposure trigger with AXI4-Lite registers
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`include "action_sync_map.vh"

module action_sync_trigger #(
	parameter        SYNC_PERIOD_CYC = `SYNC_PERIOD_CYC,
	parameter        QUEUE_DEPTH     = `QUEUE_DEPTH,
	parameter        QUEUE_AW        = 2,
	parameter [7:0]  LOCAL_QUALITY   = 8'h80,
	parameter [47:0] LOCAL_MAC       = 48'h02_00_00_00_00_01
) (
	input  wire        CLK_SYS_I,
	input  wire        RST_N_I,
	// AXI4-Lite slave
	input  wire        S_AXI_AWVALID_I,
	output wire        S_AXI_AWREADY_O,
	input  wire [7:0]  S_AXI_AWADDR_I,
	input  wire        S_AXI_WVALID_I,
	output wire        S_AXI_WREADY_O,
	input  wire [31:0] S_AXI_WDATA_I,
	input  wire [3:0]  S_AXI_WSTRB_I,
	output wire        S_AXI_BVALID_O,
	input  wire        S_AXI_BREADY_I,
	output wire [1:0]  S_AXI_BRESP_O,
	input  wire        S_AXI_ARVALID_I,
	output wire        S_AXI_ARREADY_O,
	input  wire [7:0]  S_AXI_ARADDR_I,
	output wire        S_AXI_RVALID_O,
	input  wire        S_AXI_RREADY_I,
	output wire [31:0] S_AXI_RDATA_O,
	output wire [1:0]  S_AXI_RRESP_O,
	// decoded action commands
	input  wire        CMD_VALID_I,
	input  wire [31:0] CMD_DEVICE_KEY_I,
	input  wire [31:0] CMD_GROUP_KEY_I,
	input  wire [31:0] CMD_GROUP_MASK_I,
	input  wire        CMD_HAS_TIME_I,
	input  wire [63:0] CMD_TIME_I,
	// time protocol messages and exposure trigger
	input  wire        ANNOUNCE_VALID_I,
	input  wire [7:0]  ANNOUNCE_QUALITY_I,
	input  wire [47:0] ANNOUNCE_MAC_I,
	input  wire        SYNC_VALID_I,
	input  wire [63:0] SYNC_TIME_I,
	input  wire        DELAY_RESP_VALID_I,
	input  wire [63:0] DELAY_RESP_TIME_I,
	output wire        DELAY_REQ_O,
	output wire        EXPOSE_START_O
);

	localparam [63:0] TICK = `TICK_NS;
	localparam [31:0] PERIOD = SYNC_PERIOD_CYC;
	localparam [31:0] DEPTH32 = QUEUE_DEPTH;
	localparam [31:0] RST_CTRL_W = `RST_CTRL;

	// one-hot exchange states
	localparam [3:0] S_WAIT_SYNC = 4'b0001;
	localparam [3:0] S_SEND_REQ  = 4'b0010;
	localparam [3:0] S_WAIT_RESP = 4'b0100;
	localparam [3:0] S_ADJUST    = 4'b1000;

	// ****************************************************************
	// registers
	// ****************************************************************
	reg         awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	reg  [1:0]  bresp_r, rresp_r;
	reg  [31:0] rdata_r;
	reg         aw_full_r, w_full_r;
	reg  [7:0]  awaddr_r;
	reg  [31:0] wdata_r;
	reg  [3:0]  wstrb_r;

	reg         ptp_en_r;
	reg  [31:0] dev_key_r, grp_key_r, grp_mask_r;
	reg         overflow_r;
	reg  [63:0] time_r;
	reg  [63:0] capt_r;
	reg  [7:0]  best_q_r;
	reg  [47:0] best_mac_r;
	reg         synced_r;
	reg  [3:0]  state_r;
	reg  [63:0] t1_r, t2_r, t3_r, t4_r;
	reg  [63:0] delay_r, offset_r;
	reg  [31:0] period_cnt_r;
	reg         sync_due_r;
	reg         dreq_r;
	reg         expose_r;

	wire        is_master = (best_mac_r == LOCAL_MAC);
	wire        wr_do = aw_full_r & w_full_r & ~bvalid_r;
	wire        wr_ctrl = wr_do & (awaddr_r == `REG_CTRL);
	wire        wr_cmd = wr_do & (awaddr_r == `REG_COMMAND);
	wire        do_clear = wr_cmd & wstrb_r[0] & wdata_r[`CMD_CLEAR];
	wire        do_capture = wr_cmd & wstrb_r[0] & wdata_r[`CMD_CAPTURE];
	wire        clr_overflow = wr_do & (awaddr_r == `REG_STATUS) & wstrb_r[0] & wdata_r[`STAT_OVERFLOW];

	// ****************************************************************
	// command filter
	// ****************************************************************
	wire        key_ok = (CMD_DEVICE_KEY_I == dev_key_r);
	wire        grp_ok = (CMD_GROUP_KEY_I == grp_key_r);
	wire        mask_ok = |(CMD_GROUP_MASK_I & grp_mask_r);
	wire        cmd_ok = CMD_VALID_I & synced_r & key_ok & grp_ok & mask_ok;
	wire        q_empty, q_full;
	wire [63:0] q_head;
	wire        q_push = cmd_ok & CMD_HAS_TIME_I;
	wire        q_fire = ~q_empty & (time_r >= q_head);
	wire        fire_now = cmd_ok & ~CMD_HAS_TIME_I;

	action_queue #(
		.W     (64),
		.DEPTH (QUEUE_DEPTH),
		.AW    (QUEUE_AW)
	) u_queue (
		.clk_i       (CLK_SYS_I),
		.rst_n_i     (RST_N_I),
		.push_i      (q_push),
		.push_data_i (CMD_TIME_I),
		.pop_i       (q_fire),
		.head_o      (q_head),
		.empty_o     (q_empty),
		.full_o      (q_full)
	);

	// ****************************************************************
	// byte-lane merge
	// ****************************************************************
	function [31:0] merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer i;
		begin
			merge = old_v;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					merge[i*8 +: 8] = new_v[i*8 +: 8];
				end
			end
		end
	endfunction

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awaddr_r  <= 8'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I & awready_r) begin
				awaddr_r  <= S_AXI_AWADDR_I;
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
			end
			if (S_AXI_WVALID_I & wready_r) begin
				wdata_r  <= S_AXI_WDATA_I;
				wstrb_r  <= S_AXI_WSTRB_I;
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
			end
			if (wr_do) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				case (awaddr_r)
					`REG_CTRL, `REG_STATUS, `REG_COMMAND, `REG_DEV_KEY, `REG_GRP_KEY,
					`REG_GRP_MASK, `REG_SLOT_SEL: bresp_r <= `RESP_OKAY;
					default: bresp_r <= `RESP_SLVERR;
				endcase
			end
			if (bvalid_r & S_AXI_BREADY_I) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			ptp_en_r   <= RST_CTRL_W[`CTRL_PTP_EN];
			dev_key_r  <= `RST_KEY;
			grp_key_r  <= `RST_KEY;
			grp_mask_r <= `RST_MASK;
			overflow_r <= 1'b0;
		end else begin
			if (wr_ctrl & wstrb_r[0]) begin
				ptp_en_r <= wdata_r[`CTRL_PTP_EN];
			end
			if (wr_do & (awaddr_r == `REG_DEV_KEY)) begin
				dev_key_r <= merge(dev_key_r, wdata_r, wstrb_r);
			end
			if (wr_do & (awaddr_r == `REG_GRP_KEY)) begin
				grp_key_r <= merge(grp_key_r, wdata_r, wstrb_r);
			end
			if (wr_do & (awaddr_r == `REG_GRP_MASK)) begin
				grp_mask_r <= merge(grp_mask_r, wdata_r, wstrb_r);
			end
			// a full queue drops the push even while popping; a drop in the clearing cycle still sets the flag
			if (q_push & q_full) begin
				overflow_r <= 1'b1;
			end else if (clr_overflow) begin
				overflow_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= `RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID_I & arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rresp_r   <= `RESP_OKAY;
				case (S_AXI_ARADDR_I)
					`REG_CTRL:        rdata_r <= {31'h0, ptp_en_r};
					`REG_STATUS:      rdata_r <= {27'h0, overflow_r, q_empty, q_full, is_master, synced_r};
					`REG_COMMAND:     rdata_r <= 32'h0000_0000;
					`REG_DEV_KEY:     rdata_r <= dev_key_r;
					`REG_GRP_KEY:     rdata_r <= grp_key_r;
					`REG_GRP_MASK:    rdata_r <= grp_mask_r;
					`REG_SLOT_SEL:    rdata_r <= `SLOT_SEL_VALUE;
					`REG_QUEUE_DEPTH: rdata_r <= DEPTH32;
					`REG_TIME_LO:     rdata_r <= time_r[31:0];
					`REG_TIME_HI:     rdata_r <= time_r[63:32];
					`REG_CAPT_LO:     rdata_r <= capt_r[31:0];
					`REG_CAPT_HI:     rdata_r <= capt_r[63:32];
					`REG_PATH_DELAY:  rdata_r <= delay_r[31:0];
					`REG_OFFSET:      rdata_r <= offset_r[31:0];
					default: begin
						rdata_r <= 32'h0000_0000;
						rresp_r <= `RESP_SLVERR;
					end
				endcase
			end
			if (rvalid_r & S_AXI_RREADY_I) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// best master election
	// ****************************************************************
	wire ann_better = (ANNOUNCE_QUALITY_I < best_q_r) |
		((ANNOUNCE_QUALITY_I == best_q_r) & (ANNOUNCE_MAC_I < best_mac_r));

	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			best_q_r   <= LOCAL_QUALITY;
			best_mac_r <= LOCAL_MAC;
		end else if (!ptp_en_r) begin
			best_q_r   <= LOCAL_QUALITY;
			best_mac_r <= LOCAL_MAC;
		end else if (ANNOUNCE_VALID_I & ann_better) begin
			best_q_r   <= ANNOUNCE_QUALITY_I;
			best_mac_r <= ANNOUNCE_MAC_I;
		end
	end

	// ****************************************************************
	// sync period divider
	// ****************************************************************
	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			period_cnt_r <= 32'h0000_0000;
			sync_due_r   <= 1'b0;
		end else if (!ptp_en_r) begin
			period_cnt_r <= 32'h0000_0000;
			sync_due_r   <= 1'b0;
		end else begin
			if (period_cnt_r == PERIOD - 1'b1) begin
				period_cnt_r <= 32'h0000_0000;
				sync_due_r   <= 1'b1;
			end else begin
				period_cnt_r <= period_cnt_r + 1'b1;
				if (state_r == S_SEND_REQ) begin
					sync_due_r <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// delay measurement and clock correction
	// ****************************************************************
	wire [63:0] ms_diff = t2_r - t1_r;
	wire [63:0] sm_diff = t4_r - t3_r;
	wire [63:0] sum_diff = ms_diff + sm_diff;
	wire [63:0] dif_diff = ms_diff - sm_diff;
	wire [63:0] off_now = {dif_diff[63], dif_diff[63:1]};
	wire        first_sync = ptp_en_r & ~is_master & (state_r == S_WAIT_SYNC) & SYNC_VALID_I
		& (sync_due_r | ~synced_r);

	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			state_r  <= S_WAIT_SYNC;
			t1_r     <= 64'h0;
			t2_r     <= 64'h0;
			t3_r     <= 64'h0;
			t4_r     <= 64'h0;
			delay_r  <= 64'h0;
			offset_r <= 64'h0;
			synced_r <= 1'b0;
			dreq_r   <= 1'b0;
		end else begin
			dreq_r <= 1'b0;
			if (!ptp_en_r) begin
				state_r  <= S_WAIT_SYNC;
				synced_r <= 1'b0;
			end else if (ANNOUNCE_VALID_I & ann_better) begin
				state_r  <= S_WAIT_SYNC;
				synced_r <= 1'b0;                                 // new master, resynchronise
			end else if (is_master) begin
				state_r  <= S_WAIT_SYNC;
				synced_r <= 1'b1;                                 // own clock is the reference
			end else begin
				case (state_r)
					S_WAIT_SYNC: begin
						if (first_sync) begin
							t1_r    <= SYNC_TIME_I;
							t2_r    <= time_r;
							state_r <= S_SEND_REQ;
						end
					end
					S_SEND_REQ: begin
						dreq_r  <= 1'b1;
						t3_r    <= time_r + TICK;                 // local time while the request is out
						state_r <= S_WAIT_RESP;
					end
					S_WAIT_RESP: begin
						if (DELAY_RESP_VALID_I) begin
							t4_r    <= DELAY_RESP_TIME_I;
							state_r <= S_ADJUST;
						end else if (sync_due_r) begin
							state_r <= S_WAIT_SYNC;               // lost response, retry next period
						end
					end
					S_ADJUST: begin
						delay_r  <= {sum_diff[63], sum_diff[63:1]};
						offset_r <= off_now;
						synced_r <= 1'b1;
						state_r  <= S_WAIT_SYNC;
					end
					default: state_r <= S_WAIT_SYNC;
				endcase
			end
		end
	end

	// ****************************************************************
	// local time counter
	// ****************************************************************
	wire adjust_now = ptp_en_r & ~is_master & (state_r == S_ADJUST);

	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			time_r <= `TIME_INIT;
			capt_r <= `TIME_INIT;
		end else begin
			if (do_clear) begin
				time_r <= `TIME_INIT;
			end else if (adjust_now) begin
				time_r <= time_r + TICK - off_now;
			end else begin
				time_r <= time_r + TICK;
			end
			if (do_capture) begin
				capt_r <= time_r;
			end
		end
	end

	// ****************************************************************
	// exposure trigger
	// ****************************************************************
	always @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			expose_r <= 1'b0;
		end else begin
			expose_r <= fire_now | q_fire;
		end
	end

	assign S_AXI_AWREADY_O = awready_r;
	assign S_AXI_WREADY_O  = wready_r;
	assign S_AXI_BVALID_O  = bvalid_r;
	assign S_AXI_BRESP_O   = bresp_r;
	assign S_AXI_ARREADY_O = arready_r;
	assign S_AXI_RVALID_O  = rvalid_r;
	assign S_AXI_RDATA_O   = rdata_r;
	assign S_AXI_RRESP_O   = rresp_r;
	assign DELAY_REQ_O     = dreq_r;
	assign EXPOSE_START_O  = expose_r;

endmodule // action_sync_trigger

// file: verif/ptp_master_model.sv
// network master clock model that sends sync messages and answers delay requests
module ptp_master_model #(
	parameter int DLY_NS = 200,
	parameter int GAP    = 100
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        run_i,
	input  wire logic [3:0]  resp_wait_i,
	input  wire logic        delay_req_i,
	output logic             sync_valid_o,
	output logic [63:0]      sync_time_o,
	output logic             resp_valid_o,
	output logic [63:0]      resp_time_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] mtime_r;
	logic [63:0] t4_r;
	int          gap_q;
	int          wait_q;

	initial begin
		sync_valid_o = 1'b0;
		resp_valid_o = 1'b0;
		sync_time_o  = 64'h0;
		resp_time_o  = 64'h0;
	end

	// released time fields show the inverse of their last value
	always @(posedge clk_i) begin
		sync_valid_o <= 1'b0;
		resp_valid_o <= 1'b0;
		sync_time_o  <= ~sync_time_o;
		resp_time_o  <= ~resp_time_o;
		if (!rst_n_i) begin
			mtime_r <= 64'h0000_0000_1000_0000;
			gap_q   <= 0;
			wait_q  <= 0;
		end else begin
			mtime_r <= mtime_r + 64'd40;
			gap_q   <= gap_q + 1;
			if (run_i && gap_q >= GAP) begin
				gap_q        <= 0;
				sync_valid_o <= 1'b1;
				sync_time_o  <= mtime_r + 64'd40 - DLY_NS;
			end
			if (delay_req_i) begin
				t4_r   <= mtime_r + DLY_NS;
				wait_q <= resp_wait_i;
			end else if (wait_q != 0) begin
				wait_q <= wait_q - 1;
				if (wait_q == 1) begin
					resp_valid_o <= 1'b1;
					resp_time_o  <= t4_r;
				end
			end
		end
	end
endmodule // ptp_master_model

// file: verif/action_sync_trigger_properties.sv
// port assertions of the action trigger block
module action_sync_trigger_props #(
	parameter int QUEUE_DEPTH = 4
) (
	input wire logic        CLK_SYS_I,
	input wire logic        RST_N_I,
	input wire logic        S_AXI_AWVALID_I,
	input wire logic        S_AXI_AWREADY_O,
	input wire logic [7:0]  S_AXI_AWADDR_I,
	input wire logic        S_AXI_WVALID_I,
	input wire logic        S_AXI_WREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic        S_AXI_BVALID_O,
	input wire logic        S_AXI_ARVALID_I,
	input wire logic        S_AXI_ARREADY_O,
	input wire logic [7:0]  S_AXI_ARADDR_I,
	input wire logic        S_AXI_RVALID_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic        SYNC_VALID_I,
	input wire logic        DELAY_REQ_O,
	input wire logic        EXPOSE_START_O
);
	logic [7:0] aw_addr_r;
	logic       w_en_r;
	logic       en_seen_r;

	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	// remembers whether time sync was ever enabled since reset
	always_ff @(posedge CLK_SYS_I) begin
		if (!RST_N_I) begin
			aw_addr_r <= 8'hff;
			w_en_r    <= 1'b0;
			en_seen_r <= 1'b0;
		end else begin
			if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
				aw_addr_r <= S_AXI_AWADDR_I;
			if (S_AXI_WVALID_I && S_AXI_WREADY_O)
				w_en_r <= S_AXI_WDATA_I[0];
			if (S_AXI_BVALID_O && aw_addr_r == 8'h00 && w_en_r)
				en_seen_r <= 1'b1;
		end
	end

	a_slot_reads_zero: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 8'h18
		|=> S_AXI_RVALID_O && S_AXI_RDATA_O == 32'h0000_0000) else $error("slot selector read not zero");
	a_depth_readable: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O && S_AXI_ARADDR_I == 8'h1c
		|=> S_AXI_RVALID_O && S_AXI_RDATA_O == QUEUE_DEPTH) else $error("queue depth read wrong");
	a_no_early_expose: assert property (!en_seen_r |-> !EXPOSE_START_O)
		else $error("exposure before time sync enabled");
	a_delay_req_cause: assert property (DELAY_REQ_O |-> $past(SYNC_VALID_I, 2))
		else $error("delay request without preceding sync");
	a_delay_req_pulse: assert property (DELAY_REQ_O |=> !DELAY_REQ_O [*2])
		else $error("delay request not a single pulse");
	a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
		|-> ##2 S_AXI_BVALID_O) else $error("write response late");
	a_write_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
		else $error("write accepted while response pending");
	a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
		else $error("read answer late");
endmodule // action_sync_trigger_props

bind action_sync_trigger action_sync_trigger_props #(.QUEUE_DEPTH(QUEUE_DEPTH)) props_i (
	.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
	.S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_WVALID_I(S_AXI_WVALID_I),
	.S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_BVALID_O(S_AXI_BVALID_O),
	.S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
	.S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RDATA_O(S_AXI_RDATA_O), .SYNC_VALID_I(SYNC_VALID_I),
	.DELAY_REQ_O(DELAY_REQ_O), .EXPOSE_START_O(EXPOSE_START_O));

// file: verif/tb_top.sv
// self-checking bench of the action trigger block
`include "action_sync_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DLY = 200;
	localparam logic [31:0] DEV = 32'h0000_1234;
	localparam logic [31:0] GRP = 32'h0000_5678;
	localparam logic [31:0] MSK = 32'h8000_0001;
	logic        clk, rst_n, awv, wv, bry, arv, rry, cv, cht, av, run;
	logic [7:0]  awa, ara, aq;
	logic [31:0] wd, cdk, cgk, cgm;
	logic [63:0] ct;
	logic [47:0] am;
	logic [3:0]  rw;
	wire         awr, wrd, bv, arr, rv, sv, drv, dreq, expose;
	wire  [1:0]  br, rr;
	wire  [31:0] rd;
	wire  [63:0] st, dt;
	int          miscompares, check_count;

	action_sync_trigger #(.SYNC_PERIOD_CYC(64), .LOCAL_MAC(48'h02_00_00_00_00_10)) dut (
		.CLK_SYS_I(clk), .RST_N_I(rst_n), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
		.S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
		.S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv),
		.S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
		.S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .CMD_VALID_I(cv), .CMD_DEVICE_KEY_I(cdk), .CMD_GROUP_KEY_I(cgk),
		.CMD_GROUP_MASK_I(cgm), .CMD_HAS_TIME_I(cht), .CMD_TIME_I(ct), .ANNOUNCE_VALID_I(av),
		.ANNOUNCE_QUALITY_I(aq), .ANNOUNCE_MAC_I(am), .SYNC_VALID_I(sv), .SYNC_TIME_I(st),
		.DELAY_RESP_VALID_I(drv), .DELAY_RESP_TIME_I(dt), .DELAY_REQ_O(dreq), .EXPOSE_START_O(expose));

	ptp_master_model #(.DLY_NS(DLY), .GAP(100)) pm (
		.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .resp_wait_i(rw), .delay_req_i(dreq),
		.sync_valid_o(sv), .sync_time_o(st), .resp_valid_o(drv), .resp_time_o(dt));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic tmo();
		miscompares++;
		$display("wrong value at %0t ns: wait ran out", $time);
		test_done();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk);
		awv <= 1'b1;
		awa <= a;
		wv  <= 1'b1;
		wd  <= d;
		bry <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wrd)
				wv <= 1'b0;
			if (bv && bry)
				break;
		end
		if (n == 40)
			tmo();
		bry <= 1'b0;
		chk(br, er);
	endtask

	task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		arv <= 1'b1;
		ara <= a;
		rry <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv && rry)
				break;
		end
		if (n == 40)
			tmo();
		d = rd;
		r = rr;
		rry <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rdw(a, d, r);
		chk(d, e);
	endtask

	task automatic send(input logic [31:0] dk, input logic [31:0] gk, input logic [31:0] gm, input logic ht);
		@(posedge clk);
		cv  <= 1'b1;
		cdk <= dk;
		cgk <= gk;
		cgm <= gm;
		cht <= ht;
		ct  <= pm.mtime_r + 64'd800;
		@(posedge clk);
		cv  <= 1'b0;
	endtask

	task automatic ann(input logic [7:0] q, input logic [47:0] m);
		@(posedge clk);
		av <= 1'b1;
		aq <= q;
		am <= m;
		@(posedge clk);
		av <= 1'b0;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rchk(`REG_CTRL, `RST_CTRL);
		rchk(`REG_GRP_MASK, `RST_MASK);
		rchk(`REG_QUEUE_DEPTH, 32'h0000_0004);
		wr(`REG_SLOT_SEL, 32'h0000_0005, `RESP_OKAY);
		rchk(`REG_SLOT_SEL, `SLOT_SEL_VALUE);
		wr(`REG_QUEUE_DEPTH, 32'h0000_0001, `RESP_SLVERR);
		rdw(8'h40, d, r);
		chk(r, `RESP_SLVERR);
	endtask

	task automatic t_time_cmd();
		logic [31:0] c, c2;
		logic [1:0]  r;
		wr(`REG_COMMAND, 32'h0000_0001, `RESP_OKAY);
		wr(`REG_COMMAND, 32'h0000_0002, `RESP_OKAY);
		rdw(`REG_CAPT_LO, c, r);
		chk(c < 32'd400 && c != 32'h0, 1'b1);
		rchk(`REG_CAPT_HI, 32'h0000_0000);
		repeat (5) @(posedge clk);
		rdw(`REG_CAPT_LO, c2, r);
		chk(c2, c);
		rdw(`REG_TIME_LO, c2, r);
		chk(c2 > c, 1'b1);
	endtask

	task automatic t_master();
		wr(`REG_DEV_KEY, DEV, `RESP_OKAY);
		wr(`REG_GRP_KEY, GRP, `RESP_OKAY);
		wr(`REG_GRP_MASK, MSK, `RESP_OKAY);
		send(DEV, GRP, MSK, 1'b0);
		@(posedge clk);
		chk(expose, 1'b0);
		wr(`REG_CTRL, 32'h0000_0001, `RESP_OKAY);
		rchk(`REG_STATUS, 32'h0000_000b);
		ann(8'h80, 48'h02_00_00_00_00_20);
		rchk(`REG_STATUS, 32'h0000_000b);
		ann(8'h10, 48'h02_00_00_00_00_30);
		rchk(`REG_STATUS, 32'h0000_0008);
	endtask

	task automatic t_slave();
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		run <= 1'b1;
		for (n = 0; n < 40; n++) begin
			rdw(`REG_STATUS, d, r);
			if (d[0] === 1'b1)
				break;
		end
		if (n == 40)
			tmo();
		chk(d[1:0], 2'b01);
		rchk(`REG_PATH_DELAY, DLY);
		rw <= 4'h1;
		n = 0;
		repeat (300) begin
			@(posedge clk);
			if (dreq === 1'b1)
				n++;
		end
		chk(n >= 2, 1'b1);
		rchk(`REG_OFFSET, 32'h0000_0000);
	endtask

	task automatic t_filter();
		logic [96:0] tab [5] = '{{DEV, GRP, 32'h0000_0001, 1'b1}, {DEV + 32'h1, GRP, 32'h0000_0001, 1'b0},
			{DEV, GRP + 32'h1, 32'h0000_0001, 1'b0}, {DEV, GRP, 32'h7fff_fffe, 1'b0}, {DEV, GRP, 32'h8000_0000, 1'b1}};
		for (int i = 0; i < 5; i++) begin
			send(tab[i][96:65], tab[i][64:33], tab[i][32:1], 1'b0);
			@(posedge clk);
			chk(expose, tab[i][0]);
		end
	endtask

	task automatic t_timed();
		int n;
		send(DEV, GRP, MSK, 1'b1);
		for (n = 1; n < 40; n++) begin
			@(posedge clk);
			if (expose === 1'b1)
				break;
		end
		chk(n >= 15 && n <= 25, 1'b1);
	endtask

	initial begin
		{awv, wv, bry, arv, rry, cv, cht, av, run} = '0;
		awa = 8'h00;
		ara = 8'h00;
		aq = 8'h00;
		wd = 32'h0;
		cdk = 32'h0;
		cgk = 32'h0;
		cgm = 32'h0;
		ct = 64'h0;
		am = 48'h0;
		rw = 4'h9;
		miscompares = 0;
		check_count = 0;
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_time_cmd();
		t_master();
		t_slave();
		t_filter();
		t_timed();
		test_done();
	end
endmodule // tb_top
